/* File: sdf_framer.sv */
`timescale 1ns/1ps
`default_nettype none

module sdf_framer
  import sdf_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [6:0] address_switches,
  input  wire logic [4:0] software_station_address,
  input  wire logic       software_address_write,
  input  wire sdf_cfg_type cfg,
  input  wire logic       rxd,
  output logic            txd,
  output logic            tx_enable,
  output logic            rx_byte_valid,
  output logic [7:0]      rx_byte_data,
  output logic [7:0]      rx_byte_index,
  output sdf_stat_type    status
);

  typedef enum logic [2:0] {
    S_IDLE, S_LEN, S_BODY, S_GAP, S_SEND, S_DRAIN
  } sdf_state_type;

  typedef struct packed {
    sdf_state_type            fsm;
    logic [7:0]               len;
    logic [7:0]               cnt;
    logic [7:0]               chk;
    logic [7:0]               adr;
    logic [BUF_DEPTH*8-1:0]   buf_q;
    logic [19:0]              gap;
    logic [7:0]               gap_bits;
    logic [4:0]               sw_addr;
    logic [4:0]               station;
    logic                     locked;
    logic                     loaded;
    logic [16:0]              wd_cyc;
    logic [15:0]              wd_ms;
    logic                     wd_exp;
    logic                     tx_go;
    logic                     txen;
    logic                     rbv;
    logic [7:0]               rbd;
    logic [7:0]               rbi;
    logic                     ok;
    logic                     bad;
    logic                     spec;
  } sdf_top_type;

  localparam int unsigned MS_CYC = CLK_KHZ;  // Cycles per millisecond

  sdf_top_type st_ff;      // State register
  sdf_top_type nxt_st;     // Next state
  logic [19:0] bit_cyc;    // Cycles per bit less one for baud code
  logic        u_busy;     // Transmitter busy
  logic        u_txd;      // Serial out from UART
  logic        u_rv;       // Received byte strobe
  logic [7:0]  u_rb;       // Received byte
  logic        u_re;       // Received byte error
  logic [7:0]  tx_byte;    // Byte being sent
  logic        sw_valid;   // Switch address in range
  logic [3:0]  pzd_eff;    // Process word count clamped
  logic        station_ok; // Latched address in valid range
  logic        fixed_len;  // Parameter channel of fixed length
  logic [7:0]  user_exp;   // Expected user-data bytes when fixed

  always_comb begin
    case (cfg.baud_rate_code)
      4'h4:    bit_cyc = 20'(CLK_HZ / 2400 - 1);
      4'h5:    bit_cyc = 20'(CLK_HZ / 4800 - 1);
      4'h6:    bit_cyc = 20'(CLK_HZ / 9600 - 1);
      4'h7:    bit_cyc = 20'(CLK_HZ / 19200 - 1);
      4'h8:    bit_cyc = 20'(CLK_HZ / 38400 - 1);
      4'h9:    bit_cyc = 20'(CLK_HZ / 57600 - 1);
      4'ha:    bit_cyc = 20'(CLK_HZ / 76800 - 1);
      4'hb:    bit_cyc = 20'(CLK_HZ / 93750 - 1);
      4'hc:    bit_cyc = 20'(CLK_HZ / 115200 - 1);
      4'hd:    bit_cyc = 20'(CLK_HZ / 187500 - 1);
      default: bit_cyc = 20'(CLK_HZ / 9600 - 1);
    endcase
  end

  sdf_uart u_uart (
    .clk        (clk),
    .rst        (rst),
    .bit_cycles (bit_cyc),
    .rxd        (rxd),
    .tx_start   (st_ff.tx_go),
    .tx_byte    (tx_byte),
    .tx_busy    (u_busy),
    .txd        (u_txd),
    .rx_valid   (u_rv),
    .rx_byte    (u_rb),
    .rx_err     (u_re)
  );

  assign sw_valid = (address_switches >= ADDR_MIN) && (address_switches <= ADDR_MAX);
  assign pzd_eff  = (cfg.process_word_count > PZD_MAX) ? PZD_MAX : cfg.process_word_count;
  assign tx_byte  = st_ff.buf_q[st_ff.cnt[IDX_W-1:0]*8 +: 8];
  // zero or out-of-range station never answers
  assign station_ok = ({2'b00, st_ff.station} >= ADDR_MIN) && ({2'b00, st_ff.station} <= ADDR_MAX);

  // expected user-data bytes for fixed lengths
  always_comb begin
    fixed_len = (cfg.parameter_word_count != PIV_VAR);
    case (cfg.parameter_word_count)
      7'h03:   user_exp = 8'({pzd_eff, 1'b0}) + 8'h06;  // Three parameter words
      7'h04:   user_exp = 8'({pzd_eff, 1'b0}) + 8'h08;  // Four parameter words
      default: user_exp = 8'({pzd_eff, 1'b0});          // No parameter words
    endcase
  end

  // Receive, check, reply and watchdog
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.tx_go = 1'b0;
    nxt_st.rbv   = 1'b0;
    nxt_st.ok    = 1'b0;
    nxt_st.bad   = 1'b0;
    if (software_address_write && !st_ff.locked) begin
      nxt_st.sw_addr = software_station_address;
    end
    if (!st_ff.loaded) begin
      nxt_st.loaded  = 1'b1;
      nxt_st.locked  = sw_valid;
      nxt_st.station = sw_valid ? address_switches[4:0] : st_ff.sw_addr;
    end
    if (st_ff.wd_cyc == 17'(MS_CYC - 1)) begin
      nxt_st.wd_cyc = 17'h0;
      if (st_ff.wd_ms >= cfg.receive_watchdog_time && cfg.receive_watchdog_time != 16'h0) begin
        nxt_st.wd_exp = 1'b1;
      end else begin
        nxt_st.wd_ms = st_ff.wd_ms + 16'h1;
      end
    end else begin
      nxt_st.wd_cyc = st_ff.wd_cyc + 17'h1;
    end
    case (st_ff.fsm)
      S_IDLE: begin
        if (u_rv && !u_re && u_rb == START_CHAR) begin
          nxt_st.fsm = S_LEN;
          nxt_st.chk = START_CHAR;
          nxt_st.buf_q[7:0] = START_CHAR;
        end
      end
      S_LEN: begin
        if (u_rv) begin
          // length at least address plus check
          if (u_re || u_rb < 8'h02 || u_rb > 8'(BUF_DEPTH - 2)) begin
            nxt_st.fsm = S_IDLE;
            nxt_st.bad = 1'b1;
          end else begin
            nxt_st.len = u_rb;
            nxt_st.cnt = 8'h0;
            nxt_st.chk = st_ff.chk ^ u_rb;
            nxt_st.buf_q[15:8] = u_rb;
            nxt_st.fsm = S_BODY;
          end
        end
      end
      S_BODY: begin
        if (u_rv) begin
          nxt_st.buf_q[(st_ff.cnt[IDX_W-1:0] + 6'h2)*8 +: 8] = u_rb;
          nxt_st.cnt = st_ff.cnt + 8'h1;
          nxt_st.chk = st_ff.chk ^ u_rb;
          if (st_ff.cnt == 8'h0) begin
            nxt_st.adr = u_rb;
          end else if (st_ff.cnt != st_ff.len - 8'h1) begin
            nxt_st.rbv = 1'b1;
            nxt_st.rbd = u_rb;
            nxt_st.rbi = st_ff.cnt - 8'h1;
          end
          if (st_ff.cnt == st_ff.len - 8'h1) begin
            nxt_st.fsm = S_IDLE;
            // fixed lengths must match, mirror exempt
            if (!u_re && (st_ff.chk ^ u_rb) == 8'h00 && station_ok &&
                st_ff.adr[ADR_LSB +: ADR_W] == st_ff.station && !st_ff.adr[ADR_BCAST] &&
                (st_ff.adr[ADR_MIRROR] || !fixed_len || st_ff.len == user_exp + 8'h02)) begin
              nxt_st.ok   = 1'b1;
              nxt_st.spec = st_ff.adr[ADR_SPECIAL];
              if (pzd_eff != 4'h0) begin
                nxt_st.wd_ms  = 16'h0;
                nxt_st.wd_cyc = 17'h0;
                nxt_st.wd_exp = 1'b0;
              end
              if (st_ff.adr[ADR_MIRROR]) begin
                nxt_st.fsm      = S_GAP;
                nxt_st.gap      = 20'h0;
                nxt_st.gap_bits = 8'h0;
              end
            end else begin
              nxt_st.bad = 1'b1;
            end
          end else if (u_re) begin
            nxt_st.fsm = S_IDLE;
            nxt_st.bad = 1'b1;
          end
        end
      end
      S_GAP: begin
        // idle gap in whole bit periods, so the master's stop bit ends first
        if (st_ff.gap >= bit_cyc) begin
          nxt_st.gap      = 20'h0;
          nxt_st.gap_bits = st_ff.gap_bits + 8'h1;
        end else begin
          nxt_st.gap = st_ff.gap + 20'h1;
        end
        if (st_ff.gap_bits >= 8'(GAP_CHARS * CHAR_BITS)) begin
          nxt_st.fsm   = S_SEND;
          nxt_st.cnt   = 8'h0;
          nxt_st.txen  = 1'b1;
          nxt_st.tx_go = 1'b1;
          nxt_st.len   = st_ff.len + 8'h2;
        end
      end
      S_SEND: begin
        if (!u_busy && !st_ff.tx_go) begin
          if (st_ff.cnt == st_ff.len - 8'h1) begin
            nxt_st.fsm = S_DRAIN;
          end else begin
            nxt_st.cnt   = st_ff.cnt + 8'h1;
            nxt_st.tx_go = 1'b1;
          end
        end
      end
      S_DRAIN: begin
        if (!u_busy) begin
          nxt_st.txen = 1'b0;
          nxt_st.fsm  = S_IDLE;
        end
      end
      default: nxt_st.fsm = S_IDLE;
    endcase
  end

  // Register the state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff         <= '0;
      st_ff.fsm     <= S_IDLE;
      st_ff.sw_addr <= SW_ADDR_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs from flip-flops
  logic txd_ff;  // Registered serial out
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txd_ff <= 1'b1;
    end else begin
      txd_ff <= u_txd;
    end
  end

  assign txd                            = txd_ff;
  assign tx_enable                      = st_ff.txen;
  assign rx_byte_valid                  = st_ff.rbv;
  assign rx_byte_data                   = st_ff.rbd;
  assign rx_byte_index                  = st_ff.rbi;
  assign status.telegram_ok             = st_ff.ok;
  assign status.telegram_bad            = st_ff.bad;
  assign status.special_seen            = st_ff.spec;
  assign status.watchdog_expired        = st_ff.wd_exp;
  assign status.software_address_locked = st_ff.locked;
  assign status.station_address         = st_ff.station;

  tx_only_reply_a: assert property (@(posedge clk) disable iff (rst)
    st_ff.txen |-> (st_ff.fsm == S_SEND || st_ff.fsm == S_DRAIN)) else $error("tx outside reply");
  lock_keeps_a: assert property (@(posedge clk) disable iff (rst)
    st_ff.locked && st_ff.loaded |=> $stable(st_ff.sw_addr)) else $error("locked address changed");
  station_fixed_a: assert property (@(posedge clk) disable iff (rst)
    st_ff.loaded |=> $stable(st_ff.station)) else $error("station changed");
  start_opens_a: assert property (@(posedge clk) disable iff (rst)
    (st_ff.fsm == S_IDLE && u_rv && !u_re && u_rb == START_CHAR) |=> st_ff.fsm == S_LEN)
    else $error("start missed");
  mirror_reply_a: assert property (@(posedge clk) disable iff (rst)
    $rose(st_ff.txen) |-> $past(st_ff.fsm) == S_GAP) else $error("reply without gap");
  bad_silent_a: assert property (@(posedge clk) disable iff (rst)
    st_ff.bad |-> st_ff.fsm == S_IDLE) else $error("bad frame answered");
  gap_quiet_a: assert property (@(posedge clk) disable iff (rst)
    st_ff.fsm == S_GAP |-> !st_ff.txen) else $error("driving during gap");
  wd_enable_a: assert property (@(posedge clk) disable iff (rst)
    $rose(st_ff.wd_exp) |-> cfg.receive_watchdog_time != 16'h0) else $error("watchdog misfire");
  // line idles high when not replying
  line_idle_a: assert property (@(posedge clk) disable iff (rst)
    !st_ff.txen |-> txd_ff) else $error("line driven low while idle");
  len_refuse_a: assert property (@(posedge clk) disable iff (rst)
    (st_ff.fsm == S_LEN && u_rv && u_rb < 8'h02) |=> (st_ff.bad && st_ff.fsm == S_IDLE))
    else $error("short length accepted");
  rx_index_a: assert property (@(posedge clk) disable iff (rst)
    st_ff.rbv |-> st_ff.rbi < st_ff.len - 8'h02) else $error("data index beyond length");

endmodule // sdf_framer

`default_nettype wire

/* File: sdf_master_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Bus master stand-in: frames bytes onto rxd, decodes slave replies on txd
// one slave on this bus, inside the 31-slave limit
module sdf_master_model
  import sdf_pkg::*;
#(
  parameter int BIT = 666
)
(
  input  wire logic clk,
  output logic      rxd,
  input  wire logic txd,
  input  wire logic tx_enable
);
  logic [7:0] echo_q[$];   // Reply bytes in arrival order
  int         frame_errs;  // Replies with bad parity or stop
  logic [7:0] b;           // Reply byte being assembled
  logic       par;         // Sampled reply parity bit

  // Line idles high, driven by this model
  initial begin
    rxd = 1'b1;
    frame_errs = 0;
  end

  task automatic send_byte(input logic [7:0] v);
    logic [10:0] f;
    f = {1'b1, ^v, v, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd = f[i];
      repeat (BIT) @(negedge clk);
    end
  endtask

  // Reply decoder, sampling each bit in its middle
  // parity and stop checked
  initial forever begin
    @(posedge clk);
    if (tx_enable === 1'b1 && txd === 1'b0) begin
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge clk);
        b[i] = txd;
      end
      repeat (BIT) @(posedge clk);
      par = txd;
      repeat (BIT) @(posedge clk);
      if (txd !== 1'b1 || par !== ^b) frame_errs++;
      echo_q.push_back(b);
    end
  end
endmodule // sdf_master_model

`default_nettype wire

/* File: sdf_pkg.sv */
package sdf_pkg;

  // Clock rate in kHz and derived figures
  localparam int unsigned CLK_KHZ        = 125000;
  localparam int unsigned CLK_HZ         = 125000000;
  // Telegram framing characters and address bits
  localparam logic [7:0]  START_CHAR     = 8'h02;
  localparam int unsigned ADR_SPECIAL    = 7;
  localparam int unsigned ADR_MIRROR     = 6;
  localparam int unsigned ADR_BCAST      = 5;
  localparam int unsigned ADR_LSB        = 0;
  localparam int unsigned ADR_W          = 5;
  // Station address range and software default
  localparam logic [6:0]  ADDR_MIN       = 7'h01;
  localparam logic [6:0]  ADDR_MAX       = 7'h1e;
  localparam logic [4:0]  SW_ADDR_RESET  = 5'h00;
  // Baud code range
  localparam logic [3:0]  BAUD_MIN       = 4'h4;
  localparam logic [3:0]  BAUD_MAX       = 4'hd;
  // Word counts
  localparam logic [3:0]  PZD_MAX        = 4'h8;
  localparam logic [6:0]  PIV_VAR        = 7'h7f;
  // Character frame: start, 8 data, even parity, stop
  localparam int unsigned CHAR_BITS      = 11;
  // Idle gap between telegrams, in character times
  localparam int unsigned GAP_CHARS      = 2;
  // Max telegram length in bytes (buffer depth)
  localparam int unsigned BUF_DEPTH      = 64;
  localparam int unsigned IDX_W          = 6;

  // Configuration carried to the framer
  typedef struct packed {
    logic [3:0]  baud_rate_code;
    logic [3:0]  process_word_count;
    logic [6:0]  parameter_word_count;
    logic [15:0] receive_watchdog_time;
  } sdf_cfg_type;

  // Status reported out of the framer
  typedef struct packed {
    logic        telegram_ok;
    logic        telegram_bad;
    logic        special_seen;
    logic        watchdog_expired;
    logic        software_address_locked;
    logic [4:0]  station_address;
  } sdf_stat_type;

endpackage

/* File: sdf_uart.sv */
`timescale 1ns/1ps
`default_nettype none

// Eleven-bit character serializer/deserializer
module sdf_uart
  import sdf_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [19:0] bit_cycles,
  input  wire logic        rxd,
  input  wire logic        tx_start,
  input  wire logic [7:0]  tx_byte,
  output logic             tx_busy,
  output logic             txd,
  output logic             rx_valid,
  output logic [7:0]       rx_byte,
  output logic             rx_err
);

  typedef struct packed {
    logic [19:0] rcnt;
    logic [3:0]  rbit;
    logic        ract;
    logic [10:0] rsh;
    logic        rxs;
    logic [19:0] tcnt;
    logic [3:0]  tbit;
    logic        tact;
    logic [10:0] tsh;
    logic        txd;
    logic        rv;
    logic [7:0]  rb;
    logic        re;
  } sdf_uart_type;

  sdf_uart_type st_ff;   // State register
  sdf_uart_type nxt_st;  // Next state

  // Bit timing, framing and parity
  always_comb begin
    nxt_st    = st_ff;
    nxt_st.rv = 1'b0;
    nxt_st.rxs = rxd;
    // Receiver: wait for falling start edge, sample mid-bit
    if (!st_ff.ract) begin
      if (!rxd) begin
        nxt_st.ract = 1'b1;
        nxt_st.rcnt = {1'b0, bit_cycles[19:1]};
        nxt_st.rbit = 4'h0;
      end
    end else if (st_ff.rcnt != 20'h0) begin
      nxt_st.rcnt = st_ff.rcnt - 20'h1;
    end else begin
      nxt_st.rsh  = {rxd, st_ff.rsh[10:1]};
      nxt_st.rcnt = bit_cycles;
      nxt_st.rbit = st_ff.rbit + 4'h1;
      if (st_ff.rbit == 4'(CHAR_BITS - 1)) begin
        nxt_st.ract = 1'b0;
        nxt_st.rv   = 1'b1;
        nxt_st.rb   = nxt_st.rsh[8:1];
        nxt_st.re   = nxt_st.rsh[0] | ~nxt_st.rsh[10] | (^nxt_st.rsh[9:1]);
      end
    end
    // Transmitter: shift eleven bits LSB first
    if (!st_ff.tact) begin
      if (tx_start) begin
        nxt_st.tact = 1'b1;
        nxt_st.tsh  = {1'b1, ^tx_byte, tx_byte, 1'b0};
        nxt_st.tbit = 4'h0;
        nxt_st.tcnt = bit_cycles;
        nxt_st.txd  = 1'b0;
      end
    end else if (st_ff.tcnt != 20'h0) begin
      nxt_st.tcnt = st_ff.tcnt - 20'h1;
    end else begin
      nxt_st.tcnt = bit_cycles;
      nxt_st.tbit = st_ff.tbit + 4'h1;
      nxt_st.tsh  = {1'b1, st_ff.tsh[10:1]};
      nxt_st.txd  = st_ff.tsh[1];
      if (st_ff.tbit == 4'(CHAR_BITS - 1)) begin
        nxt_st.tact = 1'b0;
        nxt_st.txd  = 1'b1;
      end
    end
  end

  // Register the state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '{txd: 1'b1, rxs: 1'b1, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tx_busy  = st_ff.tact;
  assign txd      = st_ff.txd;
  assign rx_valid = st_ff.rv;
  assign rx_byte  = st_ff.rb;
  assign rx_err   = st_ff.re;

endmodule // sdf_uart

`default_nettype wire

/* File: test_sdf_framer.sv */
`timescale 1ns/1ps
`default_nettype none

// Self-checking bench for the slave framer
module test_sdf_framer
  import sdf_pkg::*;
;
  localparam int BIT = CLK_HZ / 187500;  // Cycles per bit at code 13
  localparam int GAP_BITS = GAP_CHARS * CHAR_BITS;  // Reply gap in bit periods
  logic         clk;
  logic         rst;
  logic [6:0]   address_switches;
  logic [4:0]   software_station_address;
  logic         software_address_write;
  sdf_cfg_type  cfg;
  logic         rxd;
  logic         txd;
  logic         tx_enable;
  logic         rx_byte_valid;
  logic [7:0]   rx_byte_data;
  logic [7:0]   rx_byte_index;
  sdf_stat_type status;
  int           fail_count, n_checks, ok_cnt, bad_cnt, byte_cnt, g;
  logic [7:0]   last_data, last_idx, sent_q[$];
  logic         tx_seen;  // Any drive of the line since cleared

  sdf_framer uut (.clk(clk), .rst(rst), .address_switches(address_switches),
    .software_station_address(software_station_address), .software_address_write(software_address_write),
    .cfg(cfg), .rxd(rxd), .txd(txd), .tx_enable(tx_enable), .rx_byte_valid(rx_byte_valid),
    .rx_byte_data(rx_byte_data), .rx_byte_index(rx_byte_index), .status(status));
  sdf_master_model #(.BIT(BIT)) m (.clk(clk), .rxd(rxd), .txd(txd), .tx_enable(tx_enable));

  // 125 MHz clock
  initial clk = 1'b0;
  always #4 clk = ~clk;

  // Pulse and byte monitors
  always @(posedge clk) begin
    if (status.telegram_ok === 1'b1) ok_cnt++;
    if (status.telegram_bad === 1'b1) bad_cnt++;
    if (tx_enable === 1'b1) tx_seen = 1'b1;
    if (rx_byte_valid === 1'b1) begin
      byte_cnt++;
      last_data = rx_byte_data;
      last_idx = rx_byte_index;
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("Error %s expected %0h seen %0h", what, exp, got);
      fail_count++;
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Builds a telegram with its check byte and sends it after an idle gap
  task automatic send_tel(input logic [7:0] adr, input logic [7:0] d0, input int nd, input logic bad);
    logic [7:0] x;
    // every address sent keeps bit 5 clear
    sent_q = {START_CHAR, 8'(nd + 2), adr};
    if (nd > 0) sent_q.push_back(d0);
    x = 8'h00;
    foreach (sent_q[i]) x ^= sent_q[i];
    sent_q.push_back(bad ? ~x : x);
    repeat (2 * BIT) @(negedge clk);
    foreach (sent_q[i]) m.send_byte(sent_q[i]);
  endtask

  // Bounded wait for an ok or bad pulse beyond the given total
  task automatic wait_verdict(input int base);
    for (g = 0; g < 2 * BIT && ok_cnt + bad_cnt == base; g++) @(negedge clk);
    if (ok_cnt + bad_cnt == base) begin
      $display("Error verdict pulses expected %0d seen %0d", base + 1, ok_cnt + bad_cnt);
      fail_count++;
      close_out();
    end
  endtask

  // Switch address wins and locks the software value
  task automatic t_address();
    tx_seen = 1'b0;
    repeat (BIT) @(negedge clk);
    check("unprompted tx", 0, tx_seen);
    check("station", 5'h1e, status.station_address);
    check("locked", 1, status.software_address_locked);
    software_station_address = 5'h0a;
    software_address_write = 1'b1;
    @(negedge clk);
    software_address_write = 1'b0;
    repeat (3) @(negedge clk);
    check("station kept", 5'h1e, status.station_address);
  endtask

  // Special plus mirror telegram with one data byte is echoed whole
  task automatic t_mirror();
    int o, nb;
    o = ok_cnt;
    nb = byte_cnt;
    m.echo_q.delete();
    send_tel(8'hde, 8'ha5, 1, 1'b0);
    wait_verdict(o + bad_cnt);
    check("ok pulses", 1, ok_cnt - o);
    check("data bytes", 1, byte_cnt - nb);
    check("data value", 8'ha5, last_data);
    check("data index", 0, last_idx);
    check("special", 1, status.special_seen);
    check("watchdog off", 0, status.watchdog_expired);
    for (g = 0; g < 30 * BIT && tx_enable !== 1'b1; g++) @(negedge clk);
    check("reply gap", 1, g > (GAP_BITS - 1) * BIT && g < (GAP_BITS + 2) * BIT);
    if (tx_enable !== 1'b1) close_out();
    for (g = 0; g < 100 * BIT && tx_enable !== 1'b0; g++) @(negedge clk);
    check("reply end", 0, tx_enable);
    if (tx_enable !== 1'b0) close_out();
    check("echo len", 5, m.echo_q.size());
    foreach (sent_q[i]) check("echo byte", sent_q[i], m.echo_q[i]);
    check("reply frames", 0, m.frame_errs);
  endtask

  // Telegram that must be dropped with no reply
  task automatic t_reject(input logic [7:0] adr, input logic bad);
    int o, b0;
    o = ok_cnt;
    b0 = bad_cnt;
    tx_seen = 1'b0;
    send_tel(adr, 8'h00, 0, bad);
    wait_verdict(o + b0);
    check("bad pulses", 1, bad_cnt - b0);
    check("no ok", 0, ok_cnt - o);
    // Wait past the reply gap so a wrong mirror reply would show
    repeat (adr[ADR_MIRROR] ? (GAP_BITS + 2) * BIT : 2 * BIT) @(negedge clk);
    check("no reply", 0, tx_seen);
  endtask

  // Out-of-range switches fall back to software address
  task automatic t_invalid_switch();
    rst = 1'b1;
    address_switches = 7'h1f;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    check("station sw", 5'h00, status.station_address);
    check("unlocked", 0, status.software_address_locked);
    software_station_address = 5'h07;
    software_address_write = 1'b1;
    @(negedge clk);
    software_address_write = 1'b0;
    repeat (3) @(negedge clk);
    check("no live change", 5'h00, status.station_address);
  endtask

  // Main sequence
  initial begin
    fail_count = 0;
    n_checks = 0;
    ok_cnt = 0;
    bad_cnt = 0;
    byte_cnt = 0;
    rst = 1'b1;
    address_switches = 7'h1e;
    software_station_address = 5'h00;
    software_address_write = 1'b0;
    cfg = '{baud_rate_code: 4'hd, process_word_count: 4'h0, parameter_word_count: 7'h00,
            receive_watchdog_time: 16'h0000};
    repeat (16) @(negedge clk);
    rst = 1'b0;
    t_address();
    t_mirror();
    t_reject(8'h5e, 1'b1);
    t_reject(8'h5d, 1'b0);
    t_invalid_switch();
    close_out();
  end
endmodule // test_sdf_framer

`default_nettype wire
